// File: design/srr_cfg.svh
`ifndef SRR_CFG_SVH
`define SRR_CFG_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SRR_OFF_CTRL     12'h000
`define SRR_OFF_PRESET1  12'h004
`define SRR_OFF_PRESET2  12'h008
`define SRR_OFF_PRESET3  12'h00C
`define SRR_OFF_PRESET4  12'h010
`define SRR_OFF_LIMITS   12'h014
`define SRR_OFF_SKIP     12'h018
`define SRR_OFF_BANDW    12'h01C
`define SRR_OFF_ACCEL    12'h020
`define SRR_OFF_DECEL    12'h024
`define SRR_OFF_REF      12'h028
`define SRR_OFF_BUSV     12'h02C
`define SRR_OFF_STATUS   12'h030
`define SRR_OFF_OUTF     12'h034
`define SRR_OFF_MINDEC   12'h038
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SRR_CTL_CAL_LO   0
`define SRR_CTL_AUTO     2
`define SRR_CTL_RUN      3
`define SRR_CTL_REV      4
`define SRR_CTL_COAST    5
`define SRR_CTL_SEL_A    6
`define SRR_CTL_SEL_B    7
`define SRR_CTL_SEL_C    8
`define SRR_CTL_DB       9
`define SRR_CTL_CLRF     10
`define SRR_CTL_RST      32'h0000_0000
// ----------------------------------------------------------------
// Reset values and timing (frequency unit 0.01 Hz, time 0.1 s)
// ----------------------------------------------------------------
`define SRR_RATED_FREQ   16'h1770
`define SRR_UPPER_RST    16'h1770
`define SRR_TIME_RST     16'h012C
`define SRR_MINACC_RST   16'h0001
`define SRR_MINDEC_RST   16'h0003
`define SRR_MINDEC_DB    16'h0001
`define SRR_HI_CAL_THR   16'h0172
`define SRR_OV_THR       16'h0302
`define SRR_OV_NORM      16'h02EE
`define SRR_CLK_HZ       200000000
`define SRR_TICK_HZ      1000
`define SRR_TICK_CYC     (`SRR_CLK_HZ / `SRR_TICK_HZ)
`define SRR_OV_TRIP_TK   16'h01F4
`endif

// File: design/srr_pkg.sv
package srr_pkg;
  typedef enum logic [1:0] {SRR_CAL_AUTO, SRR_CAL_HIGH, SRR_CAL_LOW,
                            SRR_CAL_RSVD} srr_cal_e;
  typedef enum {SRR_IDLE, SRR_RUN, SRR_STOPPING} srr_state_e;
  typedef struct packed {
    logic        trans;
    logic        write;
    logic [11:0] addr;
  } srr_aphase_s;
  typedef struct packed {
    logic [15:0] lower;
    logic [15:0] upper;
  } srr_limits_s;
endpackage

// File: design/srr_speed_ramp.sv
`timescale 1ns/1ps
`include "srr_cfg.svh"
// Behaviour
// - Calibration select takes auto, high or low; manual settings override.
// - Auto calibration samples bus voltage once after power up.
// - Presets steer speed only in automatic mode.
// - Each select input works only if assigned to preset select.
// - Single closed input A, B or C picks preset 1, 2 or 3.
// - Any two closed inputs pick preset 4.
// - Preset values are limited to lower/upper frequency limits.
// - Two avoidance bands, each skip frequency plus one shared width.
// - From above, hold at band top until command at or below bottom.
// - From below, hold at band bottom until command at or above top.
// - Linear acceleration for all sources over accel time to rated.
// - Acceleration time clamped to rating minimum, 3600 s maximum.
// - Linear deceleration for all sources over decel time from rated.
// - Coast stop drops output without the decel ramp.
// - Decel setting below minimum is accepted but clamped when used.
// - Decel minimum chosen by rating and dynamic braking enable.
// - Deceleration pauses while bus voltage is high, resumes later.
// - Prolonged overvoltage during pause trips a bus overvoltage fault.
// - Start ramps from zero; running never drops below lower limit.
module srr_speed_ramp
  import srr_pkg::*;
#(
  parameter int TICK_CYC = `SRR_TICK_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        select_input_a,
  input  wire logic        select_input_b,
  input  wire logic        select_input_c,
  output logic      [15:0] out_freq_q,
  output logic             out_rev_q,
  output logic             bus_overvoltage_fault,
  output logic             ramp_hold_on_overvoltage
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  srr_aphase_s  ap_q;
  logic [31:0]  ctrl_q;
  logic [15:0]  preset_q [4];
  srr_limits_s  lim_q;
  logic [15:0]  skip1_q, skip2_q, bandw_q;
  logic [15:0]  accel_q, decel_q, ref_q, busv_q;
  logic [15:0]  minacc_q, mindec_q, mindec_db_q;
  logic         cal_lo_q, cal_done_q, fault_q, hold_q;
  logic [15:0]  ov_cnt_q;
  logic [31:0]  acc_q;
  logic [31:0]  tick_cnt_q;
  logic         tick_q;
  srr_state_e   st_q;
  logic [15:0]  freq_q;
  logic [15:0]  cmd, tgt;
  logic [15:0]  acc_eff, dec_eff;
  logic [47:0]  up_st, dn_st;
  logic         any_sel, sel_a, sel_b, sel_c;
  logic [1:0]   n_sel;
  srr_cal_e     cal_sel;

  assign cal_sel = srr_cal_e'(ctrl_q[`SRR_CTL_CAL_LO +: 2]);

  // Clamp a value into a window
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Band bounds test: value strictly inside [lo, lo+w]
  function automatic logic in_band(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] w);
    logic [16:0] hi;
    hi = {1'b0, lo} + {1'b0, w};
    in_band = (w != 16'h0000) && ({1'b0, v} > {1'b0, lo})
              && ({1'b0, v} < hi);
  endfunction

  // Whole steps due this tick {count, remainder}; short times take several
  function automatic logic [47:0] ramp_div(input logic [31:0] acc,
                                           input logic [15:0] t);
    logic [31:0] sum, thr;
    sum = acc + 32'(`SRR_RATED_FREQ);
    thr = 32'((t == 16'h0000) ? 16'h0001 : t) * 32'd100;
    ramp_div = {16'(sum / thr), sum % thr};
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else if (hready) begin
      ap_q.trans <= hsel && htrans[1];
      ap_q.write <= hwrite;
      ap_q.addr  <= haddr[11:0];
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Register writes, data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= `SRR_CTL_RST;
      preset_q[0] <= 16'h0000;
      preset_q[1] <= 16'h0000;
      preset_q[2] <= 16'h0000;
      preset_q[3] <= 16'h0000;
      lim_q.lower <= 16'h0000;
      lim_q.upper <= `SRR_UPPER_RST;
      skip1_q     <= 16'h0000;
      skip2_q     <= 16'h0000;
      bandw_q     <= 16'h0000;
      accel_q     <= `SRR_TIME_RST;
      decel_q     <= `SRR_TIME_RST;
      ref_q       <= 16'h0000;
      busv_q      <= 16'h0000;
      minacc_q    <= `SRR_MINACC_RST;
      mindec_q    <= `SRR_MINDEC_RST;
      mindec_db_q <= `SRR_MINDEC_DB;
    end else begin
      ctrl_q[`SRR_CTL_CLRF] <= 1'b0;
      if (ap_q.trans && ap_q.write) begin
        case (ap_q.addr)
          `SRR_OFF_CTRL:    ctrl_q <= hwdata;
          // Presets limited to operating window
          `SRR_OFF_PRESET1: preset_q[0] <= clamp(hwdata[15:0], lim_q.lower, lim_q.upper);
          `SRR_OFF_PRESET2: preset_q[1] <= clamp(hwdata[15:0], lim_q.lower, lim_q.upper);
          `SRR_OFF_PRESET3: preset_q[2] <= clamp(hwdata[15:0], lim_q.lower, lim_q.upper);
          `SRR_OFF_PRESET4: preset_q[3] <= clamp(hwdata[15:0], lim_q.lower, lim_q.upper);
          `SRR_OFF_LIMITS: begin
            lim_q.lower <= hwdata[15:0];
            lim_q.upper <= hwdata[31:16];
          end
          `SRR_OFF_SKIP: begin
            skip1_q <= hwdata[15:0];
            skip2_q <= hwdata[31:16];
          end
          `SRR_OFF_BANDW:  bandw_q <= hwdata[15:0];
          `SRR_OFF_ACCEL:  accel_q <= hwdata[15:0];
          `SRR_OFF_DECEL:  decel_q <= hwdata[15:0];
          `SRR_OFF_REF:    ref_q   <= hwdata[15:0];
          `SRR_OFF_BUSV:   busv_q  <= hwdata[15:0];
          `SRR_OFF_MINDEC: begin
            minacc_q    <= {8'h00, hwdata[7:0]};
            mindec_q    <= {8'h00, hwdata[15:8]};
            mindec_db_q <= {8'h00, hwdata[23:16]};
          end
          default: ;
        endcase
      end
    end
  end

  // Read mux, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr[11:0])
        `SRR_OFF_CTRL:    hrdata <= ctrl_q;
        `SRR_OFF_PRESET1: hrdata <= {16'h0000, preset_q[0]};
        `SRR_OFF_PRESET2: hrdata <= {16'h0000, preset_q[1]};
        `SRR_OFF_PRESET3: hrdata <= {16'h0000, preset_q[2]};
        `SRR_OFF_PRESET4: hrdata <= {16'h0000, preset_q[3]};
        `SRR_OFF_LIMITS:  hrdata <= {lim_q.upper, lim_q.lower};
        `SRR_OFF_SKIP:    hrdata <= {skip2_q, skip1_q};
        `SRR_OFF_BANDW:   hrdata <= {16'h0000, bandw_q};
        `SRR_OFF_ACCEL:   hrdata <= {16'h0000, accel_q};
        `SRR_OFF_DECEL:   hrdata <= {16'h0000, decel_q};
        `SRR_OFF_REF:     hrdata <= {16'h0000, ref_q};
        `SRR_OFF_BUSV:    hrdata <= {16'h0000, busv_q};
        `SRR_OFF_STATUS:  hrdata <= {26'h000_0000, st_q == SRR_RUN,
                                     cal_done_q, out_rev_q, hold_q,
                                     fault_q, cal_lo_q};
        `SRR_OFF_OUTF:    hrdata <= {16'h0000, freq_q};
        `SRR_OFF_MINDEC:  hrdata <= {8'h00, mindec_db_q[7:0],
                                     mindec_q[7:0], minacc_q[7:0]};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Supply calibration
  // ----------------------------------------------------------------
  // Auto samples first nonzero bus reading once; manual overrides
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_done_q <= 1'b0;
      cal_lo_q   <= 1'b0;
    end else begin
      case (cal_sel)
        SRR_CAL_HIGH: cal_lo_q <= 1'b0;
        SRR_CAL_LOW:  cal_lo_q <= 1'b1;
        default: begin
          if (!cal_done_q && busv_q != 16'h0000) begin
            cal_done_q <= 1'b1;
            cal_lo_q   <= (busv_q < `SRR_HI_CAL_THR);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Preset decode and command
  // ----------------------------------------------------------------
  // Inputs are active when closed and assigned as preset selects
  always_comb begin
    sel_a = select_input_a && ctrl_q[`SRR_CTL_SEL_A];
    sel_b = select_input_b && ctrl_q[`SRR_CTL_SEL_B];
    sel_c = select_input_c && ctrl_q[`SRR_CTL_SEL_C];
    n_sel = 2'(sel_a) + 2'(sel_b) + 2'(sel_c);
    any_sel = ctrl_q[`SRR_CTL_AUTO];
    cmd = ref_q;
    if (any_sel && n_sel == 2'd1) begin
      if (sel_a)      cmd = preset_q[0];
      else if (sel_b) cmd = preset_q[1];
      else            cmd = preset_q[2];
    end else if (any_sel && n_sel == 2'd2) begin
      cmd = preset_q[3];
    end
    cmd = clamp(cmd, lim_q.lower, lim_q.upper);
  end

  // Avoidance bands hold at the top edge if output is above the skip frequency, else at the bottom
  always_comb begin
    tgt = cmd;
    if (in_band(cmd, skip1_q, bandw_q)) begin
      tgt = (freq_q > skip1_q) ? 16'(skip1_q + bandw_q) : skip1_q;
    end
    if (in_band(cmd, skip2_q, bandw_q)) begin
      tgt = (freq_q > skip2_q) ? 16'(skip2_q + bandw_q) : skip2_q;
    end
  end

  // Effective ramp times with floors and ceiling
  always_comb begin
    acc_eff = clamp(accel_q, minacc_q, 16'(36000));
    dec_eff = clamp(decel_q,
                    ctrl_q[`SRR_CTL_DB] ? mindec_db_q : mindec_q,
                    16'(36000));
    up_st   = ramp_div(acc_q, acc_eff);
    dn_st   = ramp_div(acc_q, dec_eff);
  end

  // ----------------------------------------------------------------
  // Ramp generator
  // ----------------------------------------------------------------
  // Tick divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // Overvoltage hold and trip counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q   <= 1'b0;
      fault_q  <= 1'b0;
      ov_cnt_q <= 16'h0000;
    end else begin
      if (busv_q >= `SRR_OV_THR) hold_q <= 1'b1;
      else if (busv_q <= `SRR_OV_NORM) hold_q <= 1'b0;
      if (hold_q && tick_q) ov_cnt_q <= ov_cnt_q + 16'h0001;
      else if (!hold_q) ov_cnt_q <= 16'h0000;
      if (ov_cnt_q >= `SRR_OV_TRIP_TK) fault_q <= 1'b1;
      else if (ctrl_q[`SRR_CTL_CLRF]) fault_q <= 1'b0;
    end
  end

  // Run state, frequency and fractional accumulator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= SRR_IDLE;
      freq_q    <= 16'h0000;
      acc_q     <= 32'h0000_0000;
      out_rev_q <= 1'b0;
    end else begin
      case (st_q)
        SRR_IDLE: begin
          freq_q <= 16'h0000;
          acc_q  <= 32'h0000_0000;
          out_rev_q <= ctrl_q[`SRR_CTL_REV];
          if (ctrl_q[`SRR_CTL_RUN] && !fault_q) st_q <= SRR_RUN;
        end
        SRR_RUN: begin
          if (fault_q || (!ctrl_q[`SRR_CTL_RUN] &&
                          ctrl_q[`SRR_CTL_COAST])) begin
            st_q   <= SRR_IDLE;
            freq_q <= 16'h0000;
          end else if (!ctrl_q[`SRR_CTL_RUN] ||
                       ctrl_q[`SRR_CTL_REV] != out_rev_q) begin
            st_q <= SRR_STOPPING;
          end else if (tick_q) begin
            // Rated freq per ramp time; stop exactly on the target
            if (freq_q < tgt) begin
              acc_q  <= up_st[31:0];
              freq_q <= (tgt - freq_q > up_st[47:32]) ?
                        freq_q + up_st[47:32] : tgt;
            end else if (freq_q > tgt && !hold_q) begin
              acc_q  <= dn_st[31:0];
              freq_q <= (freq_q - tgt > dn_st[47:32]) ?
                        freq_q - dn_st[47:32] : tgt;
            end
          end
        end
        SRR_STOPPING: begin
          if (fault_q || ctrl_q[`SRR_CTL_COAST] || freq_q == 16'h0000) begin
            st_q   <= SRR_IDLE;
            freq_q <= 16'h0000;
          end else if (tick_q && !hold_q) begin
            acc_q  <= dn_st[31:0];
            freq_q <= (freq_q > dn_st[47:32]) ?
                      freq_q - dn_st[47:32] : 16'h0000;
          end
        end
        default: st_q <= SRR_IDLE;
      endcase
    end
  end

  assign out_freq_q               = freq_q;
  assign bus_overvoltage_fault    = fault_q;
  assign ramp_hold_on_overvoltage = hold_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_fault_sticks: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(fault_q) |=> fault_q)
    else $error("fault dropped after trip");
  a_hold_no_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    (hold_q && $past(hold_q) && st_q != SRR_IDLE) |=>
      (freq_q >= $past(freq_q) || st_q == SRR_IDLE))
    else $error("frequency fell during hold");
  a_step_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == SRR_RUN && $past(st_q) == SRR_RUN) |->
      (freq_q - $past(freq_q) <= 16'(`SRR_RATED_FREQ / 100) ||
       $past(freq_q) - freq_q <= 16'(`SRR_RATED_FREQ / 100)))
    else $error("ramp step too large");
  a_idle_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == SRR_IDLE |=> (st_q != SRR_IDLE || freq_q == 16'h0000))
    else $error("idle with nonzero output");
  a_coast_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == SRR_RUN && !ctrl_q[`SRR_CTL_RUN] && ctrl_q[`SRR_CTL_COAST]
     && !fault_q) |=> (st_q == SRR_IDLE && freq_q == 16'h0000))
    else $error("coast stop used ramp");
  a_cal_manual: assert property (@(posedge hclk) disable iff (!hresetn)
    cal_sel == SRR_CAL_LOW |=> cal_lo_q)
    else $error("manual low not applied");
  a_preset_lim: assert property (@(posedge hclk) disable iff (!hresetn)
    (ap_q.trans && ap_q.write && ap_q.addr == `SRR_OFF_PRESET4) |=>
      preset_q[3] <= $past(lim_q.upper))
    else $error("preset above upper limit");
  a_dec_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    dec_eff >= (ctrl_q[`SRR_CTL_DB] ? mindec_db_q : mindec_q))
    else $error("decel below floor");
endmodule

// File: verif/speed_reference_ramp_tb.sv
`timescale 1ns/1ps
`include "srr_cfg.svh"
module speed_reference_ramp_tb;
  import srr_pkg::*;
  localparam int          TCYC  = 20;
  localparam logic [31:0] C_AUT = 32'h0000_0004;
  localparam logic [31:0] C_RUN = 32'h0000_0008;
  localparam logic [31:0] C_CST = 32'h0000_0020;
  localparam logic [31:0] C_CLR = 32'h0000_0400;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        sel_a;
  logic        sel_b;
  logic        sel_c;
  logic        fault;
  logic        hold;
  logic        rev;
  logic        over;
  logic [15:0] freq;
  logic [15:0] ceil_v;
  logic [2:0]  close_req;
  logic [15:0] pre [4];
  logic [31:0] rd;
  logic [15:0] f1;
  int          bad_count;
  int          comparisons;
  int          cyc;
  integer      seed;

  srr_speed_ramp #(.TICK_CYC(TCYC)) srr_speed_ramp_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .select_input_a(sel_a), .select_input_b(sel_b),
    .select_input_c(sel_c), .out_freq_q(freq), .out_rev_q(rev),
    .bus_overvoltage_fault(fault), .ramp_hold_on_overvoltage(hold));

  srr_term_model srr_term_model_i (
    .hclk(hclk), .hresetn(hresetn), .close_req(close_req),
    .freq_ceiling(ceil_v), .out_freq_q(freq), .select_input_a(sel_a),
    .select_input_b(sel_b), .select_input_c(sel_c), .over_seen_q(over));

  // ------------------------------------------------------------
  // Clock and run limit
  // ------------------------------------------------------------
  // Free running 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Cuts a hang short
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  // One single-word transfer; waits out any wait states
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0_0000, a};
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp, "register read");
  endtask
  // Waits for the output to land on a value, then compares
  task automatic settle(input logic [15:0] exp);
    int n;
    n = 0;
    while (freq !== exp && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    // Must stay put for a few ticks, not merely pass through
    repeat (3 * TCYC) @(posedge hclk);
    chk({16'h0000, freq}, {16'h0000, exp}, "output frequency");
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Reference picked by contacts, assignment and control mode
  function automatic logic [15:0] exp_ref(input logic [2:0] cl,
      input logic [2:0] asg, input logic aut, input logic [15:0] nref);
    if (!aut) begin
      return nref;
    end
    case (cl & asg)
      3'b001: return pre[0];
      3'b010: return pre[1];
      3'b100: return pre[2];
      3'b011, 3'b101, 3'b110: return pre[3];
      default: return nref;
    endcase
  endfunction
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [2:0] cl;
    logic [2:0] asg;
    logic       aut;
    seed = 32'h3c2f3195;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    close_req = 3'b000;
    ceil_v = 16'h00A0;
    bad_count = 0;
    comparisons = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk({hresp, rev, fault, hold, freq}, 32'h0, "reset outputs");
    rchk(`SRR_OFF_CTRL, `SRR_CTL_RST);
    rchk(`SRR_OFF_MINDEC, 32'h0001_0301);
    rchk(12'h100, 32'h0000_0000);
    done("reset");
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_0100);
    rchk(`SRR_OFF_STATUS, 32'h0000_0011);
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_0302);
    bus(1'b1, `SRR_OFF_STATUS, 32'h0000_0000);
    bus(1'b0, `SRR_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0011, 32'h0000_0011, "auto cal once");
    bus(1'b1, `SRR_OFF_CTRL, 32'h0000_0001);
    bus(1'b0, `SRR_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000, "manual high");
    bus(1'b1, `SRR_OFF_CTRL, 32'h0000_0002);
    bus(1'b0, `SRR_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0001, "manual low");
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_0100);
    done("calibration");
    bus(1'b1, `SRR_OFF_LIMITS, 32'h0100_0010);
    bus(1'b1, `SRR_OFF_PRESET1, 32'h0000_0005);
    rchk(`SRR_OFF_PRESET1, 32'h0000_0010);
    bus(1'b1, `SRR_OFF_PRESET2, 32'h0000_0200);
    rchk(`SRR_OFF_PRESET2, 32'h0000_0100);
    bus(1'b1, `SRR_OFF_LIMITS, 32'h1770_0000);
    bus(1'b1, `SRR_OFF_ACCEL, 32'h0000_0001);
    bus(1'b1, `SRR_OFF_DECEL, 32'h0000_0000);
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0020);
    for (int i = 0; i < 4; i++) begin
      pre[i] = 16'h0020 + 16'($random(seed) & 32'h0000_007F);
      bus(1'b1, 12'(`SRR_OFF_PRESET1 + 4 * i), {16'h0000, pre[i]});
    end
    done("limits");
    for (int i = 0; i < 12; i++) begin
      cl = (i == 0) ? 3'b111 : 3'($random(seed));
      asg = (i < 6) ? 3'b111 : 3'($random(seed));
      aut = (i < 9) ? 1'b1 : 1'b0;
      bus(1'b1, `SRR_OFF_CTRL, (aut ? C_AUT : 32'h0) | C_RUN
          | {23'h0, asg, 6'h00});
      @(posedge hclk);
      close_req <= cl;
      settle(exp_ref(cl, asg, aut, 16'h0020));
    end
    rchk(`SRR_OFF_OUTF, {16'h0000, exp_ref(cl, asg, aut, 16'h0020)});
    done("presets");
    close_req <= 3'b000;
    bus(1'b1, `SRR_OFF_CTRL, C_RUN);
    bus(1'b1, `SRR_OFF_SKIP, 32'h1000_0060);
    bus(1'b1, `SRR_OFF_BANDW, 32'h0000_0020);
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0040);
    settle(16'h0040);
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0070);
    settle(16'h0060);
    repeat (400) @(posedge hclk);
    chk({16'h0000, freq}, 32'h0000_0060, "hold below band");
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0090);
    settle(16'h0090);
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0070);
    settle(16'h0080);
    repeat (400) @(posedge hclk);
    chk({16'h0000, freq}, 32'h0000_0080, "hold above band");
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0060);
    settle(16'h0060);
    done("avoidance");
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0020);
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_0302);
    repeat (40) @(posedge hclk);
    f1 = freq;
    repeat (200) @(posedge hclk);
    chk({hold, freq}, {1'b1, f1}, "ramp paused");
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_02EE);
    settle(16'h0020);
    chk({31'h0, hold}, 32'h0000_0000, "pause released");
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0060);
    settle(16'h0060);
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0020);
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_0302);
    repeat (500 * TCYC - 200) @(posedge hclk);
    chk({31'h0, fault}, 32'h0000_0000, "no early trip");
    repeat (400) @(posedge hclk);
    chk({31'h0, fault}, 32'h0000_0001, "overvoltage trip");
    bus(1'b1, `SRR_OFF_BUSV, 32'h0000_02EE);
    bus(1'b1, `SRR_OFF_CTRL, C_RUN | C_CLR);
    repeat (2) @(posedge hclk);
    chk({31'h0, fault}, 32'h0000_0000, "fault cleared");
    done("overvoltage");
    bus(1'b1, `SRR_OFF_CTRL, C_RUN);
    settle(16'h0020);
    bus(1'b1, `SRR_OFF_CTRL, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk({31'h0, freq !== 16'h0000}, 32'h0000_0001, "ramped stop");
    settle(16'h0000);
    bus(1'b1, `SRR_OFF_LIMITS, 32'h1770_0030);
    bus(1'b1, `SRR_OFF_REF, 32'h0000_0000);
    bus(1'b1, `SRR_OFF_CTRL, C_RUN);
    settle(16'h0030);
    bus(1'b1, `SRR_OFF_CTRL, C_CST);
    repeat (4) @(posedge hclk);
    chk({16'h0000, freq}, 32'h0000_0000, "coast stop");
    chk({31'h0, over}, 32'h0000_0000, "above ceiling");
    bus(1'b1, `SRR_OFF_CTRL, 32'h0000_0010);
    repeat (2) @(posedge hclk);
    chk({30'h0, hresp, rev}, 32'h0000_0001, "direction latch");
    done("stopping");
    close_out();
  end
endmodule

// File: verif/srr_term_model.sv
`timescale 1ns/1ps
// Contact strip on one side, inverter stage on the other
module srr_term_model
  import srr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [2:0]  close_req,
  input  wire logic [15:0] freq_ceiling,
  input  wire logic [15:0] out_freq_q,
  output logic             select_input_a,
  output logic             select_input_b,
  output logic             select_input_c,
  output logic             over_seen_q
);
  // ------------------------------------------------------------
  // Contacts
  // ------------------------------------------------------------
  // Contacts settle one edge after the request, like a debounced strip
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select_input_a <= 1'b0;
      select_input_b <= 1'b0;
      select_input_c <= 1'b0;
    end else begin
      select_input_a <= close_req[0];
      select_input_b <= close_req[1];
      select_input_c <= close_req[2];
    end
  end
  // ------------------------------------------------------------
  // Inverter watch
  // ------------------------------------------------------------
  // Remembers any command above what the stage may be driven at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      over_seen_q <= 1'b0;
    end else if (out_freq_q > freq_ceiling) begin
      over_seen_q <= 1'b1;
    end
  end
endmodule
